// File: hw/sat_readout.sv
`timescale 1ns/100ps
`default_nettype none
// What this block and its host must do
// RL1: inputs above upper reference give all ones, below lower reference all zeros.
// RL2: host gives a rising clock within 9.5 us after tenth fall on long transfers.
// RL3: shift clock ignored until select low has persisted the setup interval.
// RL4: host waits the select setup interval before clocking data.
// RL5: sampling runs from third to tenth falling shift-clock edge.
// RL6: conversion after sampling ends within 21 us.
// RL7: host aborts by lowering select within 9 us of tenth fall.
// RL8: select change accepted only after persisting 1.425 us.
// RL9: select low drives data output with msb within 1.3 us.
// RL10: select high releases data output within 180 ns.
// RL11: accepted select fall starts a cycle and aborts any running one.
// RL12: aborted cycle keeps the previous result.
// RL13: host starts new transfer only after conversion has finished.
// RL14: previous result shifts out msb first, one bit per fall, then zeros.
// RL15: after tenth fall convert on internal clock, then load result.
module sat_readout (
	// clock and reset
	input  wire logic           clock,
	input  wire logic           sys_rst,
	// serial pins
	input  wire logic           cs_n_pin,
	input  wire logic           io_clk_pin,
	output var  logic           data_out,
	output var  logic           data_oe,
	// analog levels as codes
	input  wire sat_pkg::sat_level_t ain_level,
	input  wire sat_pkg::sat_level_t ref_hi_level,
	input  wire sat_pkg::sat_level_t ref_lo_level
);
	import sat_pkg::*;

	sat_conv_if cv ();

	logic              cs_m_q, cs_s_q, io_m_q, io_s_q, io_d_q;
	logic [3*AIN_W-1:0] lv_m_q, lv_s_q;
	logic              cs_filt_q;
	logic [FILT_W-1:0] stable_q;
	sat_state_t        state_q;
	logic [FALL_W-1:0] fall_q;
	logic              start_q, abort_q;
	sat_level_t        sample_q;
	sat_code_t         result_q, sh_q;
	logic              dout_q, oe_q;
	logic [AGE_W-1:0]  age_q;
	logic              tail_q;
	logic              io_fall, filt_hit, acc_fall, acc_rise, tenth;

	// two-stage synchronisers for every pin
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cs_m_q <= 1'b1;
			cs_s_q <= 1'b1;
			io_m_q <= 1'b0;
			io_s_q <= 1'b0;
			io_d_q <= 1'b0;
			lv_m_q <= '0;
			lv_s_q <= '0;
		end else begin
			cs_m_q <= cs_n_pin;
			cs_s_q <= cs_m_q;
			io_m_q <= io_clk_pin;
			io_s_q <= io_m_q;
			io_d_q <= io_s_q;
			lv_m_q <= {ain_level, ref_hi_level, ref_lo_level};
			lv_s_q <= lv_m_q;
		end
	end

	assign io_fall  = io_d_q && !io_s_q;
	assign filt_hit = (cs_s_q != cs_filt_q) && stable_q == FILT_W'(SETUP_CYC - 1);
	assign acc_fall = filt_hit && !cs_s_q;
	assign acc_rise = filt_hit && cs_s_q;
	// a select change accepted in the same cycle wins, so no start without the convert state
	assign tenth    = state_q == ST_ACCESS && io_fall && fall_q == FALL_W'(LAST_FALL - 1) && !filt_hit;

	// a select glitch shorter than the setup interval never reaches the sequencer
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cs_filt_q <= 1'b1;
			stable_q  <= '0;
		end else if (cs_s_q == cs_filt_q) begin
			stable_q <= '0;
		end else if (filt_hit) begin
			cs_filt_q <= cs_s_q; // RL8
			stable_q  <= '0;
		end else begin
			stable_q <= stable_q + FILT_W'(1);
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_q <= ST_IDLE;
		end else if (acc_fall) begin
			state_q <= ST_ACCESS; // RL11
		end else begin
			case (state_q)
				ST_ACCESS: begin
					if (acc_rise)
						state_q <= ST_IDLE;
					else if (tenth)
						state_q <= ST_CONVERT; // RL15
				end
				ST_CONVERT: begin
					if (cv.done)
						state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// shift clock counted only while select is accepted low
	always_ff @(posedge clock) begin
		if (sys_rst || acc_fall) begin
			fall_q <= '0;
		end else if (state_q == ST_ACCESS && io_fall && fall_q != FALL_W'(MAX_FALLS)) begin
			fall_q <= fall_q + FALL_W'(1); // RL3
		end
	end

	// sample tracks the input from the third fall and freezes on the tenth
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sample_q <= '0;
		end else if (state_q == ST_ACCESS && fall_q >= FALL_W'(SAMPLE_FALL)
			&& fall_q < FALL_W'(LAST_FALL)) begin
			sample_q <= lv_s_q[3*AIN_W-1:2*AIN_W]; // RL5
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			start_q <= 1'b0;
			abort_q <= 1'b0;
		end else begin
			start_q <= tenth; // RL15
			abort_q <= acc_fall && state_q == ST_CONVERT; // RL11
		end
	end

	// abort wins over a completion in the same cycle, so the old result survives
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			result_q <= '0;
		end else if (state_q == ST_CONVERT && cv.done && !acc_fall) begin
			result_q <= cv.code; // RL12
		end
	end

	// output enable follows the synchronised pin, not the filter, to meet enable time
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			oe_q   <= 1'b0;
			dout_q <= 1'b0;
			sh_q   <= '0;
		end else begin
			oe_q   <= !cs_s_q; // RL9 RL10
			dout_q <= cs_s_q ? 1'b0 : sh_q[RES_BITS-1];
			if (cs_s_q)
				sh_q <= result_q;
			else if (state_q == ST_ACCESS && io_fall)
				sh_q <= {sh_q[RES_BITS-2:0], 1'b0}; // RL14
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst || state_q != ST_CONVERT)
			age_q <= '0;
		else
			age_q <= age_q + AGE_W'(1);
	end

	// marks the stretch from the tenth fall until select is seen high again
	always_ff @(posedge clock) begin
		if (sys_rst || cs_s_q)
			tail_q <= 1'b0;
		else if (tenth)
			tail_q <= 1'b1;
	end

	assign cv.start  = start_q;
	assign cv.abort  = abort_q;
	assign cv.sample = sample_q;
	assign cv.ref_hi = lv_s_q[2*AIN_W-1:AIN_W];
	assign cv.ref_lo = lv_s_q[AIN_W-1:0];
	assign data_out  = dout_q;
	assign data_oe   = oe_q;

	sat_sar u_sar (
		.clock   (clock),
		.sys_rst (sys_rst),
		.cv      (cv.sar)
	);

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	oe_enable_a: assert property ($fell(cs_s_q) |-> ##1 oe_q && dout_q == $past(sh_q[RES_BITS-1])) // RL9
		else $error("data output not enabled after select fall");
	oe_release_a: assert property ($rose(cs_s_q) |=> !oe_q) // RL10
		else $error("data output not released after select rise");
	filter_level_a: assert property ($changed(cs_filt_q) |-> $past(cs_s_q) == cs_filt_q
		&& $past(stable_q) == FILT_W'(SETUP_CYC - 1)) // RL8
		else $error("select accepted without full persistence");
	clock_ignored_a: assert property ($changed(fall_q) && fall_q != '0 |-> $past(state_q) == ST_ACCESS) // RL3
		else $error("shift clock counted while not selected");
	conv_start_a: assert property (tenth |=> state_q == ST_CONVERT ##0 cv.start ##1 cv.busy) // RL15
		else $error("conversion did not start on tenth fall");
	conv_bound_a: assert property (age_q <= AGE_W'(CONV_CYC)) // RL6
		else $error("conversion exceeded its bound");
	abort_keep_a: assert property (acc_fall && state_q == ST_CONVERT |=> state_q == ST_ACCESS
		&& $stable(result_q) ##1 !cv.busy) // RL11 RL12
		else $error("abort did not restart or changed result");
	sat_high_a: assert property (cv.done && $past(cv.sample) >= $past(cv.ref_hi) |-> cv.code == '1) // RL1
		else $error("high input not saturated");
	tail_zero_a: assert property (tail_q && $past(tail_q) && !cs_s_q |-> !dout_q) // RL14
		else $error("extra clocks produced result bits");
	load_done_a: assert property (state_q == ST_CONVERT && cv.done && !acc_fall |=> result_q == $past(cv.code)) // RL15
		else $error("result not loaded at completion");

	full_cycle_c: cover property (state_q == ST_CONVERT && cv.done && age_q <= AGE_W'(CONV_CYC));
	abort_c: cover property (abort_q);
	glitch_c: cover property ($fell(cs_s_q) ##[1:100] $rose(cs_s_q));
	sat_c: cover property (cv.done && cv.code == '1);
endmodule : sat_readout
`default_nettype wire

// File: inc/sat_pkg.sv
`default_nettype none
package sat_pkg;
	localparam int CLK_PERIOD_NS = 8;
	// select setup plus two internal clock edges, least persistence of a select level
	localparam int SETUP_NS      = 1425;
	localparam int SETUP_CYC     = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// longest conversion after the sampling window
	localparam int CONV_NS       = 21000;
	localparam int CONV_CYC      = CONV_NS / CLK_PERIOD_NS;
	localparam int RES_BITS      = 10;
	localparam int AIN_W         = 12;
	// one spare step slot keeps the load and clamp cycles inside the bound
	localparam int STEP_CYC      = CONV_CYC / (RES_BITS + 1);
	localparam int SAMPLE_FALL   = 3;
	localparam int LAST_FALL     = 10;
	localparam int MAX_FALLS     = 16;
	localparam int FALL_W        = 5;
	localparam int FILT_W        = 8;
	localparam int STEP_W        = 8;
	localparam int IDX_W         = 4;
	localparam int AGE_W         = 12;

	typedef logic [RES_BITS-1:0] sat_code_t;
	typedef logic [AIN_W-1:0]    sat_level_t;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'h1,
		ST_ACCESS  = 3'h2,
		ST_CONVERT = 3'h4
	} sat_state_t;
endpackage : sat_pkg
`default_nettype wire

// File: inc/sat_conv_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sat_conv_if;
	import sat_pkg::*;
	logic       start;
	logic       abort;
	sat_level_t sample;
	sat_level_t ref_hi;
	sat_level_t ref_lo;
	logic       busy;
	logic       done;
	sat_code_t  code;

	modport ctl (output start, output abort, output sample, output ref_hi, output ref_lo,
		input busy, input done, input code);
	modport sar (input start, input abort, input sample, input ref_hi, input ref_lo,
		output busy, output done, output code);
endinterface : sat_conv_if
`default_nettype wire

// File: hw/sat_sar.sv
`timescale 1ns/100ps
`default_nettype none
module sat_sar (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// conversion control
	sat_conv_if.sar  cv
);
	import sat_pkg::*;

	logic                  busy_q;
	logic [IDX_W-1:0]      idx_q;
	logic [STEP_W-1:0]     step_q;
	sat_code_t             trial_q;
	sat_code_t             code_q;
	logic                  done_q;
	sat_code_t             weight;
	sat_code_t             probe;
	logic [AIN_W+RES_BITS-1:0] prod;
	logic [AIN_W:0]        level;
	logic                  keep;

	assign weight = sat_code_t'(1) << idx_q;
	assign probe  = trial_q | weight;
	assign prod   = probe * (cv.ref_hi - cv.ref_lo);
	assign level  = {1'b0, cv.ref_lo} + {1'b0, prod[AIN_W+RES_BITS-1:RES_BITS]};
	assign keep   = {1'b0, cv.sample} >= level;

	// successive approximation, one bit per step slot, msb first
	always_ff @(posedge clock) begin
		if (sys_rst || cv.abort) begin
			busy_q  <= 1'b0;
			idx_q   <= '0;
			step_q  <= '0;
			trial_q <= '0;
		end else if (cv.start) begin
			busy_q  <= 1'b1;
			idx_q   <= IDX_W'(RES_BITS - 1);
			step_q  <= '0;
			trial_q <= '0;
		end else if (busy_q) begin
			if (step_q == STEP_W'(STEP_CYC - 1)) begin // RL6
				step_q <= '0;
				if (keep)
					trial_q <= probe;
				if (idx_q == '0)
					busy_q <= 1'b0;
				else
					idx_q <= idx_q - IDX_W'(1);
			end else begin
				step_q <= step_q + STEP_W'(1);
			end
		end
	end

	// result clamp at the reference rails
	always_ff @(posedge clock) begin
		if (sys_rst || cv.abort) begin
			done_q <= 1'b0;
			code_q <= '0;
		end else begin
			done_q <= busy_q && idx_q == '0 && step_q == STEP_W'(STEP_CYC - 1);
			if (busy_q && idx_q == '0 && step_q == STEP_W'(STEP_CYC - 1)) begin
				if (cv.sample >= cv.ref_hi)
					code_q <= '1; // RL1
				else if (cv.sample <= cv.ref_lo)
					code_q <= '0; // RL1
				else
					code_q <= keep ? probe : trial_q;
			end
		end
	end

	assign cv.busy = busy_q;
	assign cv.done = done_q;
	assign cv.code = code_q;
endmodule : sat_sar
`default_nettype wire

// File: test/sat_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module sat_host_model (
	// clock
	input  wire logic clock,
	// serial pins
	output var  logic cs_n_pin,
	output var  logic io_clk_pin,
	input  wire logic data_out,
	input  wire logic data_oe
);
	logic last_q;
	logic wire_lvl;
	// a released line must not keep its last level
	assign wire_lvl = data_oe ? data_out : ~last_q;
	always_ff @(posedge clock) begin
		last_q <= wire_lvl;
	end
	initial begin
		cs_n_pin   = 1'b1;
		io_clk_pin = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge clock);
	endtask : wt
	task automatic pulse(input int n);
		wt(300);
		cs_n_pin = 1'b0;
		wt(n);
		cs_n_pin = 1'b1;
	endtask : pulse
	task automatic frame(input int nclk, input bit early, output logic [15:0] bits,
		output logic oe_on, output logic oe_off);
		bits = 16'h0000;
		wt(1);
		cs_n_pin = 1'b0;
		// early clocks break the setup on purpose and must be ignored
		if (early) begin
			for (int i = 0; i < 3; i++) begin
				wt(4);
				io_clk_pin = 1'b1;
				wt(4);
				io_clk_pin = 1'b0;
			end
		end
		wt(early ? 139 : 163);
		oe_on = data_oe;
		wt(87);
		for (int i = 0; i < nclk; i++) begin
			io_clk_pin = 1'b1;
			wt(4);
			bits[15-i] = wire_lvl;
			io_clk_pin = 1'b0;
			wt(4);
		end
		wt(25);
		cs_n_pin = 1'b1;
		wt(22);
		oe_off = data_oe;
		io_clk_pin = 1'b0;
	endtask : frame
endmodule : sat_host_model
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import sat_pkg::*;
	localparam sat_level_t REF_HI = 12'h810;
	localparam sat_level_t REF_LO = 12'h010;
	localparam sat_level_t A_HI   = 12'hFFF;
	localparam sat_level_t A_LO   = 12'h000;
	// odd offset keeps every probe off an exact tie
	localparam sat_level_t A_MID  = 12'h2BB;
	localparam sat_code_t  C_MID  = 10'h155;
	logic        clock;
	logic        sys_rst;
	logic        cs_n_pin;
	logic        io_clk_pin;
	logic        data_out;
	logic        data_oe;
	sat_level_t  ain_level;
	int          fail_count;
	int          cmp_count;
	logic [15:0] bits;
	logic        oe_on;
	logic        oe_off;
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	sat_readout dut (
		.clock        (clock),
		.sys_rst      (sys_rst),
		.cs_n_pin     (cs_n_pin),
		.io_clk_pin   (io_clk_pin),
		.data_out     (data_out),
		.data_oe      (data_oe),
		.ain_level    (ain_level),
		.ref_hi_level (REF_HI),
		.ref_lo_level (REF_LO)
	);
	sat_host_model host (
		.clock      (clock),
		.cs_n_pin   (cs_n_pin),
		.io_clk_pin (io_clk_pin),
		.data_out   (data_out),
		.data_oe    (data_oe)
	);
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude
	task automatic chk_code(input string name, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk_code
	task automatic chk_flag(input string name, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %b seen %b", name, exp, got);
		end
	endtask : chk_flag
	task automatic rd(input int nclk, input bit early, input sat_code_t exp);
		host.frame(nclk, early, bits, oe_on, oe_off);
		chk_flag("enable after select fall", 1'b1, oe_on);
		chk_flag("release after select rise", 1'b0, oe_off);
		chk_code("shifted result", {exp, 6'h00}, bits);
	endtask : rd
	// next select fall only once the conversion is over
	task automatic settle();
		host.wt(2600);
	endtask : settle
	task automatic t_reset();
		host.wt(4);
		chk_flag("enable after reset", 1'b0, data_oe);
		chk_flag("data after reset", 1'b0, data_out);
		$display("test reset done");
	endtask : t_reset
	task automatic t_saturate();
		ain_level = A_HI;
		rd(10, 1'b0, 10'h000);
		ain_level = A_LO;
		settle();
		rd(10, 1'b0, 10'h3FF);
		ain_level = A_MID;
		settle();
		rd(16, 1'b0, 10'h000);
		settle();
		$display("test saturate done");
	endtask : t_saturate
	task automatic t_early();
		ain_level = A_HI;
		rd(10, 1'b1, C_MID);
		settle();
		$display("test early clock done");
	endtask : t_early
	task automatic t_abort();
		ain_level = A_LO;
		rd(10, 1'b0, 10'h3FF);
		ain_level = A_MID;
		host.wt(375);
		rd(10, 1'b0, 10'h3FF);
		host.pulse(100);
		settle();
		rd(10, 1'b0, C_MID);
		$display("test abort done");
	endtask : t_abort
	// a frame cut before the tenth fall must not start a conversion
	task automatic t_cut();
		settle();
		ain_level = A_HI;
		host.frame(5, 1'b0, bits, oe_on, oe_off);
		chk_code("cut frame bits", {C_MID[9:5], 11'h000}, bits);
		chk_flag("release after cut frame", 1'b0, oe_off);
		host.wt(300);
		rd(10, 1'b0, C_MID);
		settle();
		$display("test cut frame done");
	endtask : t_cut
	initial begin
		repeat (40000) @(posedge clock);
		fail_count++;
		$display("[ERR] run time limit expected end seen hang");
		conclude();
	end
	initial begin
		sys_rst    = 1'b1;
		ain_level  = A_LO;
		fail_count = 0;
		cmp_count  = 0;
		repeat (8) @(negedge clock);
		sys_rst = 1'b0;
		t_reset();
		t_saturate();
		t_early();
		t_abort();
		t_cut();
		conclude();
	end
endmodule : testbench
`default_nettype wire
